// File: rtl/spc_port_control.sv
`timescale 1ns/1ps
// Behaviour
// [R1] buffer write during a shift sets the sticky write collision flag
// [R2] slave byte done with buffer unread sets overflow, new byte dropped
// [R3] master mode never raises the overflow flag
// [R4] enable hands serial pins to the port, disable returns them
// [R5] software sets each pin direction while the port is enabled
// [R6] idle serial clock level follows the polarity bit
// [R7] mode 1010: master, clock is system clock / (4 * (divider + 1))
// [R8] modes 0010 and 0001: master at system clock / 64 and / 16
// [R9] mode 0011: master, clock is timer two output / 2
// [R10] modes 0101/0100: slave on pin clock; select ignored or honoured
// [R11] software programs no mode code outside the listed ones
// [R12] software avoids divider zero in programmable master mode
module spc_port_control (
    input wire logic clock,
    input wire logic resetn,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [spc_pkg::AW-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic serial_clock_pin,
    output logic serial_clock_drive,
    output logic serial_clock_drive_en,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_pin_en,
    input wire logic slave_select_pin_n,
    input wire logic timer_two_output,
    output logic [3:0] pin_takeover,
    output logic irq
);
    import spc_pkg::*;

    // ****************************************************
    // reset release
    // ****************************************************
    logic [1:0] rst_sync;
    wire rst_n = rst_sync[1];

    // two stages keep release clean of the async edge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end

    // ****************************************************
    // state
    // ****************************************************
    logic write_collision_flag;
    logic ovf;
    logic en;
    logic clock_idle_polarity;
    logic [3:0] mode;
    logic [7:0] divr;
    logic [7:0] rxbuf;
    logic bf;
    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] ien;
    logic tick;

    spc_shift_if sif();

    // ****************************************************
    // bus decode
    // ****************************************************
    wire req = wb_cyc & wb_stb;
    wire acc = req & wb_ack;
    wire wr = acc & wb_we & wb_sel[0];
    wire rd = acc & ~wb_we;
    wire wr_ctrl = wr & (wb_adr == A_CTRL);
    wire wr_div = wr & (wb_adr == A_DIV);
    wire wr_buf = wr & (wb_adr == A_BUF);
    wire wr_iclr = wr & (wb_adr == A_ICLR);
    wire wr_ien = wr & (wb_adr == A_IEN);
    wire rd_buf = rd & (wb_adr == A_BUF);

    // ****************************************************
    // mode decode
    // ****************************************************
    // reserved codes leave the port neither master nor slave
    wire master = en & is_master(mode); // R7 R8 R9
    wire slave = en & is_slave(mode);
    wire ss_used = mode == MD_SLSS;
    wire ss_act = slave & (!ss_used | !slave_select_pin_n); // R10
    wire run = master & sif.busy;

    // ****************************************************
    // events
    // ****************************************************
    wire write_collision_flag_ev = wr_buf & sif.busy; // R1
    wire ovf_ev = sif.done & slave & bf; // R2 R3
    wire take_rx = sif.done & !ovf_ev;
    // a colliding write is dropped, the byte on the wire goes on
    wire load = wr_buf & !sif.busy & en;
    wire [IRQ_W-1:0] ev = {sif.done, ovf_ev, write_collision_flag_ev};

    // ****************************************************
    // next values; hardware set wins over a software clear
    // ****************************************************
    wire next_write_collision_flag = write_collision_flag_ev | (wr_ctrl ? write_collision_flag & wb_dat_w[B_WRITE_COLLISION_FLAG] : write_collision_flag);
    wire next_ovf = ovf_ev | (wr_ctrl ? ovf & wb_dat_w[B_OVF] : ovf);
    wire next_bf = take_rx | (bf & !rd_buf);
    wire [IRQ_W-1:0] clr = wr_iclr ? wb_dat_w[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] next_istat = ev | (istat & ~clr);
    wire [3:0] take = {en & ss_used, en, en, en}; // R4

    // ****************************************************
    // read mux, unmapped words read zero
    // ****************************************************
    wire [7:0] ctrl_rd = {write_collision_flag, ovf, en, clock_idle_polarity, mode};
    wire [31:0] rdata =
        (wb_adr == A_CTRL) ? {24'h000000, ctrl_rd} :
        (wb_adr == A_DIV) ? {24'h000000, divr} :
        (wb_adr == A_BUF) ? {24'h000000, rxbuf} :
        (wb_adr == A_ISTAT) ? {29'h00000000, istat} :
        (wb_adr == A_IEN) ? {29'h00000000, ien} : 32'h00000000;

    // ****************************************************
    // engine hookup
    // ****************************************************
    assign sif.load = load;
    assign sif.tx_data = wb_dat_w[7:0];
    assign sif.master = master;
    assign sif.clock_idle_polarity = clock_idle_polarity;
    assign sif.ss_act = ss_act;
    assign sif.tick = tick;
    assign sif.sck_in = serial_clock_pin;
    assign sif.sdi = serial_in_pin;

    spc_shift u_shift (
        .clock(clock),
        .rst_n(rst_n),
        .sif(sif)
    );

    // divider zero still gives a clock, just the fastest one
    spc_clkgen u_clkgen (
        .clock(clock),
        .rst_n(rst_n),
        .mode(mode),
        .div(divr),
        .timer_two_output(timer_two_output),
        .run(run),
        .tick(tick)
    );

    // ****************************************************
    // bus slave: one wait state, ack for every address
    // ****************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack <= 1'b0;
            wb_dat_r <= 32'h00000000;
        end else begin
            wb_ack <= req & ~wb_ack;
            wb_dat_r <= rdata;
        end
    end

    // control register and divider
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {write_collision_flag, ovf, en, clock_idle_polarity, mode} <= CTRL_RST;
            divr <= DIV_RST;
        end else begin
            write_collision_flag <= next_write_collision_flag; // R1
            ovf <= next_ovf; // R2
            if (wr_ctrl) begin
                en <= wb_dat_w[B_EN]; // R4
                clock_idle_polarity <= wb_dat_w[B_CKP]; // R6
                mode <= wb_dat_w[3:0];
            end
            if (wr_div)
                divr <= wb_dat_w[7:0];
        end
    end

    // receive buffer keeps the old byte on overflow
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rxbuf <= 8'h00;
            bf <= 1'b0;
        end else begin
            bf <= next_bf;
            if (take_rx)
                rxbuf <= sif.rx_data; // R2
        end
    end

    // interrupt status, enable and output
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            istat <= '0;
            ien <= '0;
            irq <= 1'b0;
        end else begin
            istat <= next_istat;
            if (wr_ien)
                ien <= wb_dat_w[IRQ_W-1:0];
            irq <= |(istat & ien);
        end
    end

    // pins; outputs registered so they line up with each other
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            serial_clock_drive <= 1'b0;
            serial_clock_drive_en <= 1'b0;
            serial_out_pin <= 1'b0;
            serial_out_pin_en <= 1'b0;
            pin_takeover <= 4'h0;
        end else begin
            serial_clock_drive <= master ? sif.sck_out : clock_idle_polarity; // R6
            serial_clock_drive_en <= master;
            serial_out_pin <= sif.sdo;
            serial_out_pin_en <= master | ss_act; // R10
            pin_takeover <= take; // R4
        end
    end

    // ****************************************************
    // checks
    // ****************************************************
    logic [CNT_W-1:0] gap;
    logic gap_ok;

    // cycles since the last clock tick, for the rate checks
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gap <= '0;
            gap_ok <= 1'b0;
        end else if (!run) begin
            gap <= '0;
            gap_ok <= 1'b0;
        end else begin
            gap <= tick ? '0 : gap + 10'h001;
            gap_ok <= gap_ok | tick;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_wr_busy;
        wr_buf && sif.busy;
    endsequence
    sequence s_slave_full;
        sif.done && slave && bf;
    endsequence
    sequence s_idle_port;
        (en && !sif.busy && $stable(clock_idle_polarity) && $stable(master))[*3];
    endsequence
    sequence s_deselect;
        (en && ss_used && slave_select_pin_n)[*2];
    endsequence

    // flags and receive buffer
    write_collision_flag_set_a: assert property (s_wr_busy |=> write_collision_flag && istat[I_WRITE_COLLISION_FLAG]) // [R1]
        else $error("write collision flag missed");
    ovf_set_a: assert property (s_slave_full |=> ovf && // [R2]
        rxbuf == $past(rxbuf))
        else $error("overflow not flagged or buffer overwritten");
    rx_take_a: assert property (sif.done && slave && !bf |=> bf && // [R2]
        rxbuf == $past(sif.rx_data))
        else $error("received byte not stored");
    ovf_master_a: assert property ($rose(ovf) |-> $past(slave)) // [R3]
        else $error("overflow raised outside slave operation");

    // pins and serial clock
    pin_route_a: assert property (1'b1 |=> pin_takeover[P_SCK] == // [R4]
        $past(en) && (pin_takeover == 4'h0) == !$past(en))
        else $error("pin takeover does not follow enable");
    pin_release_a: assert property (!en |=> !serial_clock_drive_en && // [R4]
        !serial_out_pin_en)
        else $error("disabled port still drives a pin");
    idle_level_a: assert property (s_idle_port |-> // [R6]
        serial_clock_drive == clock_idle_polarity)
        else $error("serial clock not at idle level");
    div_rate_a: assert property (tick && gap_ok && mode == MD_MDIV |-> // [R7]
        gap == {1'b0, divr, 1'b0} + 10'h001)
        else $error("programmable clock rate wrong");
    fixed_rate_a: assert property (tick && gap_ok && // [R8]
        mode == MD_MS64 |-> gap == HALF_F64 - 10'h001)
        else $error("divide by 64 clock rate wrong");
    fast_rate_a: assert property (tick && gap_ok && // [R8]
        mode == MD_MS16 |-> gap == HALF_F16 - 10'h001)
        else $error("divide by 16 clock rate wrong");
    timer_edge_a: assert property (tick && mode == MD_MTMR |-> // [R9]
        $rose(timer_two_output))
        else $error("timer clock tick without timer edge");

    // slave select
    slave_sel_a: assert property (s_deselect |-> !sif.busy && // [R10]
        !serial_out_pin_en)
        else $error("deselected slave still active");
    sel_ignore_a: assert property (en && mode == MD_SLNS |=> // [R10]
        serial_out_pin_en)
        else $error("slave ignoring select leaves data undriven");
endmodule // spc_port_control

// File: rtl/spc_pkg.sv
package spc_pkg;
    // ****************************************************
    // register map, word aligned on the wishbone bus
    // ****************************************************
    localparam int AW = 5;
    localparam logic [AW-1:0] A_CTRL = 5'h00;
    localparam logic [AW-1:0] A_DIV = 5'h04;
    localparam logic [AW-1:0] A_BUF = 5'h08;
    localparam logic [AW-1:0] A_ISTAT = 5'h0c;
    localparam logic [AW-1:0] A_ICLR = 5'h10;
    localparam logic [AW-1:0] A_IEN = 5'h14;

    // port_control_one field positions
    localparam int B_WRITE_COLLISION_FLAG = 7;
    localparam int B_OVF = 6;
    localparam int B_EN = 5;
    localparam int B_CKP = 4;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DIV_RST = 8'h00;

    // interrupt status layout
    localparam int IRQ_W = 3;
    localparam int I_WRITE_COLLISION_FLAG = 0;
    localparam int I_OVF = 1;
    localparam int I_DONE = 2;

    // pin_takeover bit order
    localparam int P_SCK = 0;
    localparam int P_SDO = 1;
    localparam int P_SDI = 2;
    localparam int P_SS = 3;

    // ****************************************************
    // clock generation and shifting
    // ****************************************************
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] HALF_F64 = 10'h020;
    localparam logic [CNT_W-1:0] HALF_F16 = 10'h008;
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [3:0] {
        MD_MS16 = 4'b0001,
        MD_MS64 = 4'b0010,
        MD_MTMR = 4'b0011,
        MD_SLSS = 4'b0100,
        MD_SLNS = 4'b0101,
        MD_MDIV = 4'b1010
    } spc_mode_t;

    typedef enum logic {
        SH_IDLE = 1'b0,
        SH_RUN = 1'b1
    } spc_state_t;

    function automatic logic is_master(input logic [3:0] m);
        return m == MD_MS16 || m == MD_MS64 || m == MD_MTMR ||
            m == MD_MDIV;
    endfunction

    function automatic logic is_slave(input logic [3:0] m);
        return m == MD_SLSS || m == MD_SLNS;
    endfunction

    // half period of the master clock in system cycles
    function automatic logic [CNT_W-1:0] half_of(input logic [3:0] m,
                                                 input logic [7:0] d);
        case (m)
            MD_MS64: half_of = HALF_F64;
            MD_MS16: half_of = HALF_F16;
            default: half_of = {1'b0, d, 1'b0} + 10'h002;
        endcase
    endfunction
endpackage

// File: rtl/spc_shift_if.sv
`timescale 1ns/1ps
// ****************************************************
// link between port control and shift engine
// ****************************************************
interface spc_shift_if;
    logic load;
    logic [7:0] tx_data;
    logic master;
    logic clock_idle_polarity;
    logic ss_act;
    logic tick;
    logic sck_in;
    logic sdi;
    logic busy;
    logic done;
    logic [7:0] rx_data;
    logic sck_out;
    logic sdo;
    modport ctl(output load, tx_data, master, clock_idle_polarity, ss_act, tick, sck_in,
                sdi, input busy, done, rx_data, sck_out, sdo);
    modport eng(input load, tx_data, master, clock_idle_polarity, ss_act, tick, sck_in,
                sdi, output busy, done, rx_data, sck_out, sdo);
endinterface

// File: rtl/spc_clkgen.sv
`timescale 1ns/1ps
// ****************************************************
// master clock source: divider or timer two edges
// ****************************************************
module spc_clkgen (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] mode,
    input wire logic [7:0] div,
    input wire logic timer_two_output,
    input wire logic run,
    output logic tick
);
    import spc_pkg::*;

    logic [CNT_W-1:0] cnt;
    logic tmr_prev;
    wire [CNT_W-1:0] half = half_of(mode, div);
    wire cnt_end = cnt == half - 10'h001;
    wire tmr_edge = timer_two_output & ~tmr_prev;

    // each tick toggles the clock, so timer edges give half rate
    assign tick = run & ((mode == MD_MTMR) ? tmr_edge : cnt_end); // R9

    // counter restarts so the first half period is full length
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            tmr_prev <= 1'b0;
        end else begin
            tmr_prev <= timer_two_output;
            cnt <= (!run || cnt_end) ? '0 : cnt + 10'h001; // R7 R8
        end
    end
endmodule // spc_clkgen

// File: rtl/spc_shift.sv
`timescale 1ns/1ps
// ****************************************************
// eight bit shift engine, msb first
// ****************************************************
module spc_shift (
    input wire logic clock,
    input wire logic rst_n,
    spc_shift_if.eng sif
);
    import spc_pkg::*;

    spc_state_t state;
    logic [2:0] cnt;
    logic [7:0] sr;
    logic sbit;
    logic sck_prev;

    // leading edge samples, trailing edge shifts
    wire run = state == SH_RUN;
    wire m_lead = sif.master & run & sif.tick & (sif.sck_out == sif.clock_idle_polarity);
    wire m_trail = sif.master & run & sif.tick & (sif.sck_out != sif.clock_idle_polarity);
    wire s_lead = !sif.master & sif.ss_act & (sif.sck_in != sif.clock_idle_polarity) &
        (sck_prev == sif.clock_idle_polarity);
    wire s_trail = !sif.master & sif.ss_act & run &
        (sif.sck_in == sif.clock_idle_polarity) & (sck_prev != sif.clock_idle_polarity);
    wire lead = m_lead | s_lead;
    wire trail = m_trail | s_trail;
    wire last = trail & (cnt == LAST_BIT);
    wire [7:0] shifted = {sr[6:0], sbit};

    assign sif.busy = run;
    assign sif.sdo = sr[7];

    // data path; a deselected slave forgets a partial byte
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= SH_IDLE;
            cnt <= 3'h0;
            sr <= 8'h00;
            sbit <= 1'b0;
            sif.done <= 1'b0;
            sif.rx_data <= 8'h00;
        end else begin
            sif.done <= last;
            if (sif.load && !run) begin
                sr <= sif.tx_data;
                cnt <= 3'h0;
                state <= sif.master ? SH_RUN : SH_IDLE; // R3
            end else if (!sif.master && !sif.ss_act) begin
                state <= SH_IDLE; // R10
                cnt <= 3'h0;
            end else begin
                if (lead) begin
                    sbit <= sif.sdi;
                    state <= SH_RUN;
                end
                if (trail) begin
                    sr <= shifted;
                    cnt <= cnt + 3'h1;
                end
                if (last) begin
                    state <= SH_IDLE;
                    sif.rx_data <= shifted;
                end
            end
        end
    end

    // master clock rests at the idle level between bytes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sif.sck_out <= 1'b0;
            sck_prev <= 1'b0;
        end else begin
            sck_prev <= sif.sck_in;
            if (!run || !sif.master)
                sif.sck_out <= sif.clock_idle_polarity; // R6
            else if (sif.tick)
                sif.sck_out <= ~sif.sck_out; // R7
        end
    end
endmodule // spc_shift

// File: dv/spc_peer.sv
`timescale 1ns/1ps
// ****************************************************
// spi peer: slave while the port masters, master while it is slave
// ****************************************************
module spc_peer (
    input wire logic clock,
    input wire logic clock_idle_polarity,
    input wire logic load,
    input wire logic go,
    input wire logic use_ss,
    input wire logic [7:0] tx,
    input wire logic sck_drv,
    input wire logic sck_en,
    input wire logic sdo,
    output logic sck,
    output logic sdi,
    output logic ss_n,
    output logic [7:0] rx
);
    logic [7:0] sh = 8'h00;
    logic [3:0] nbit = 4'h8;
    logic [1:0] tm = 2'h0;
    logic busy = 1'b0;
    logic prev = 1'b0;
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
        ss_n = 1'b1;
        rx = 8'h00;
    end
    // leading edge samples, trailing edge shifts, msb first;
    // sdi toggles outside frames so a stale bit is never read as valid
    always @(posedge clock) begin
        prev <= sck_drv;
        if (load || go) begin
            sh <= tx;
            sdi <= tx[7];
            nbit <= 4'h0;
            busy <= go;
            ss_n <= ~(go & use_ss);
            tm <= 2'h0;
        end else if (busy) begin
            tm <= tm + 2'h1;
            if (tm == 2'h3 && nbit == 4'h8) begin
                busy <= 1'b0;
                ss_n <= 1'b1;
            end else if (tm == 2'h3 && sck == clock_idle_polarity) begin
                sck <= ~clock_idle_polarity;
                rx <= {rx[6:0], sdo};
            end else if (tm == 2'h3) begin
                sck <= clock_idle_polarity;
                sh <= {sh[6:0], 1'b0};
                sdi <= sh[6];
                nbit <= nbit + 4'h1;
            end
        end else if (sck_en && sck_drv != prev && nbit != 4'h8) begin
            if (sck_drv != clock_idle_polarity) begin
                rx <= {rx[6:0], sdo};
            end else begin
                sh <= {sh[6:0], 1'b0};
                sdi <= sh[6];
                nbit <= nbit + 4'h1;
            end
        end else if (nbit == 4'h8) begin
            sdi <= ~sdi;
            sck <= clock_idle_polarity;
        end
    end
endmodule // spc_peer

// File: dv/spi_port_control_bench.sv
`timescale 1ns/1ps
// ****************************************************
// self-checking bench for the serial port control block
// ****************************************************
module spi_port_control_bench;
    import spc_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [AW-1:0] wb_adr = 5'h00;
    logic [31:0] wb_dat_w = 32'h0, wb_dat_r;
    logic wb_ack, sck_pin, sck_drv, sck_en, sdo, sdo_en, irq;
    logic timer = 1'b0, pload = 1'b0, pgo = 1'b0, puse = 1'b0;
    logic cur_ckp = 1'b0, psck, psdi, pss_n;
    logic [7:0] ptx = 8'h00, prx;
    logic [3:0] pin_takeover;
    logic [2:0] tcnt = 3'h0;
    logic [31:0] seed = 32'h00000034;
    logic [31:0] expq[$];
    int num_errors = 0, cmp_count = 0, cyc_cnt = 0;
    // the port drives the clock wire only in master modes
    assign sck_pin = sck_en ? sck_drv : psck;
    spc_port_control uut (.clock(clock), .resetn(resetn),
        .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
        .wb_sel(4'h1), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .serial_clock_pin(sck_pin),
        .serial_clock_drive(sck_drv), .serial_clock_drive_en(sck_en),
        .serial_in_pin(psdi), .serial_out_pin(sdo),
        .serial_out_pin_en(sdo_en), .slave_select_pin_n(pss_n),
        .timer_two_output(timer), .pin_takeover(pin_takeover), .irq(irq));
    spc_peer peer (.clock(clock), .clock_idle_polarity(cur_ckp), .load(pload), .go(pgo),
        .use_ss(puse), .tx(ptx), .sck_drv(sck_drv), .sck_en(sck_en),
        .sdo(sdo), .sck(psck), .sdi(psdi), .ss_n(pss_n), .rx(prx));
    initial begin
        forever #4 clock = ~clock;
    end
    // timer rises every 6 cycles; cycle limit cuts a hang short
    always @(posedge clock) begin
        tcnt <= (tcnt == 3'h2) ? 3'h0 : tcnt + 3'h1;
        if (tcnt == 3'h2) timer <= ~timer;
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // classic single cycle; held until ack is sampled high
    task automatic wb(input logic we, input logic [4:0] a,
                      input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat_w <= {24'h0, d};
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) num_errors++;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        expq.push_back(e);
        wb(1'b0, a, 8'h00);
    endtask
    // each read answer is matched with the oldest note
    always @(posedge clock) begin
        if (wb_ack === 1'b1 && wb_cyc && !wb_we && expq.size() != 0)
            chk(wb_dat_r, expq.pop_front());
    end
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 3000) num_errors++;
    endtask
    task automatic till_edge(output int h);
        logic s;
        s = sck_drv;
        h = 0;
        while (sck_drv === s && h < 500) begin
            @(posedge clock);
            h++;
        end
    endtask
    task automatic peer_go(input logic [7:0] p, input logic g,
                           input logic ss);
        ptx <= p;
        puse <= ss;
        pgo <= g;
        pload <= ~g;
        @(posedge clock);
        pgo <= 1'b0;
        pload <= 1'b0;
    endtask
    // one master byte: clock rate, idle level, both data directions
    task automatic xfer_m(input logic [3:0] m, input logic k,
                          input logic [7:0] dv, input int exph,
                          input logic coll);
        logic [7:0] c, d, p;
        int h;
        c = {3'b001, k, m};
        d = 8'(rnd());
        p = 8'(rnd());
        cur_ckp <= k;
        wb(1'b1, A_DIV, dv);
        wb(1'b1, A_CTRL, c);
        repeat (3) @(posedge clock);
        chk(32'(pin_takeover), 32'h7);
        chk(32'({sck_en, sdo_en}), 32'h3);
        chk(32'(sck_drv), 32'(k));
        peer_go(p, 1'b0, 1'b0);
        wb(1'b1, A_BUF, d);
        till_edge(h);
        till_edge(h);
        chk(32'(h), 32'(exph));
        if (coll) wb(1'b1, A_BUF, ~d);
        wait_irq();
        chk(32'(sck_drv), 32'(k));
        chk(32'(prx), 32'(d));
        rd(A_ISTAT, coll ? 32'h5 : 32'h4);
        rd(A_CTRL, {24'h0, coll, c[6:0]});
        rd(A_BUF, 32'(p));
        wb(1'b1, A_CTRL, c);
        wb(1'b1, A_ICLR, 8'h07);
    endtask
    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        logic [7:0] d, p;
        int h;
        logic [3:0] mt[4];
        logic [4:0] ra[7];
        mt = '{4'h1, 4'h2, 4'ha, 4'h3};
        ra = '{A_CTRL, A_DIV, A_BUF, A_ISTAT, A_ICLR, A_IEN, 5'h1c};
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
        chk(32'(pin_takeover), 32'h0);
        foreach (ra[i]) rd(ra[i], 32'h0);
        wb(1'b1, A_IEN, 8'h04);
        for (int i = 0; i < 4; i++) begin
            d = 8'(rnd() % 3) + 8'h01;
            h = mt[i] == 4'h2 ? 32 : mt[i] == 4'h1 ? 8 :
                mt[i] == 4'h3 ? 6 : 2 * (d + 1);
            xfer_m(mt[i], i[0], d, h, i == 0);
        end
        // interrupt: raise by collision, mask, clear
        wb(1'b1, A_IEN, 8'h01);
        wb(1'b1, A_BUF, 8'h5a);
        wb(1'b1, A_BUF, 8'h5a);
        repeat (3) @(posedge clock);
        chk(32'(irq), 32'h1);
        wb(1'b1, A_IEN, 8'h04);
        repeat (3) @(posedge clock);
        chk(32'(irq), 32'h0);
        wait_irq();
        wb(1'b1, A_ICLR, 8'h07);
        repeat (3) @(posedge clock);
        chk(32'(irq), 32'h0);
        wb(1'b0, A_BUF, 8'h00);
        // slave, select ignored; unread buffer overflows
        cur_ckp <= 1'b0;
        wb(1'b1, A_CTRL, 8'h05);
        repeat (3) @(posedge clock);
        chk(32'(pin_takeover), 32'h0);
        wb(1'b1, A_IEN, 8'h06);
        wb(1'b1, A_CTRL, 8'h25);
        repeat (3) @(posedge clock);
        chk(32'(pin_takeover), 32'h7);
        chk(32'({sck_en, sdo_en}), 32'h1);
        d = 8'(rnd());
        p = 8'(rnd());
        wb(1'b1, A_BUF, d);
        peer_go(p, 1'b1, 1'b0);
        wait_irq();
        chk(32'(prx), 32'(d));
        wb(1'b1, A_ICLR, 8'h07);
        // irq falls a cycle after the clear; a stale high ends the wait early
        repeat (2) @(posedge clock);
        peer_go(~p, 1'b1, 1'b0);
        wait_irq();
        rd(A_CTRL, 32'h65);
        rd(A_BUF, 32'(p));
        // slave with select honoured
        cur_ckp <= 1'b1;
        wb(1'b1, A_CTRL, 8'h34);
        wb(1'b1, A_ICLR, 8'h07);
        repeat (3) @(posedge clock);
        chk(32'(pin_takeover), 32'hf);
        chk(32'({sck_en, sdo_en}), 32'h0);
        d = 8'(rnd());
        p = 8'(rnd());
        wb(1'b1, A_BUF, d);
        peer_go(p, 1'b1, 1'b1);
        wait_irq();
        chk(32'(prx), 32'(d));
        rd(A_BUF, 32'(p));
        end_sim();
    end
endmodule // spi_port_control_bench
